/* core/emb_map.vh */
// Constants for the external memory bus control block.
// Assumes inclusion by bare name from files under core/.
`ifndef EMB_MAP_VH
`define EMB_MAP_VH
// Address space codes of a request
`define EMB_SPACE_PROG 2'h0
`define EMB_SPACE_DATA 2'h1
`define EMB_SPACE_IO 2'h2
// Mode register field position and reset value
`define EMB_MODE_RDFN_BIT 15
`define EMB_MODE_RESET 16'h0000
// Cycle counts
`define EMB_SETUP_CYCLES 1
`endif

/* core/emb_sync.v */
// Two-flop synchroniser for one level from outside the clock domain.
// Assumes a single clock and asynchronous active-high reset.
`timescale 1ns/1ps
module emb_sync (
  clock,
  reset,
  async_in,
  sync_out
);
  parameter RESET_VALUE = 1'b1;
  input wire clock;
  input wire reset;
  input wire async_in;
  output wire sync_out;
  reg meta_q;
  reg sync_q;

  // First flop feeds only the second
  always @(posedge clock or posedge reset) begin
    if (reset) begin
      meta_q <= RESET_VALUE;
      sync_q <= RESET_VALUE;
    end else begin
      meta_q <= async_in;
      sync_q <= meta_q;
    end
  end

  assign sync_out = sync_q;
endmodule

/* core/emb_ctrl.v */
// External memory bus control: space selects, direction, read select,
// write strobe and cycle strobe, with ready-driven cycle stretching.
// Assumes a core-side request port on the same clock; ready and
// bus_float_n arrive from pins and are synchronised here.
// Behaviour
// - program_space_select is high except low during an off-chip program access.
// - data_space_select is high except low during an off-chip data access.
// - io_space_select is high except low during an external I/O access.
// - ready sampled low stretches the access one cycle and is sampled again until high.
// - transfer_direction rests high and is low only during an external write.
// - all control outputs float while bus_float_n is low.
// - read_select is asserted on every external read of any space.
// - mode bit 15 makes the read pin carry inverted direction during an access and rest high when set, read_select when clear.
// - the data bus is driven from the falling edge of write_strobe.
// - write_strobe is asserted on every external write of any space.
// - cycle_strobe is high except low in the strobe phase of an external bus cycle.
`timescale 1ns/1ps
`include "emb_map.vh"
module emb_ctrl (
  clock,
  reset,
  req_valid,
  req_space,
  req_write,
  req_wdata,
  req_ready,
  done_pulse,
  rdata,
  mode_wr,
  mode_wdata,
  mode_value,
  ready,
  bus_float_n,
  data_in,
  program_space_select_o,
  program_space_select_oe,
  data_space_select_o,
  data_space_select_oe,
  io_space_select_o,
  io_space_select_oe,
  transfer_direction_o,
  transfer_direction_oe,
  read_pin_o,
  read_pin_oe,
  write_strobe_o,
  write_strobe_oe,
  cycle_strobe_o,
  cycle_strobe_oe,
  data_out,
  data_oe
);
  input wire clock;
  input wire reset;
  input wire req_valid;
  input wire [1:0] req_space;
  input wire req_write;
  input wire [15:0] req_wdata;
  output reg req_ready;
  output reg done_pulse;
  output reg [15:0] rdata;
  input wire mode_wr;
  input wire [15:0] mode_wdata;
  output reg [15:0] mode_value;
  input wire ready;
  input wire bus_float_n;
  input wire [15:0] data_in;
  output reg program_space_select_o;
  output reg program_space_select_oe;
  output reg data_space_select_o;
  output reg data_space_select_oe;
  output reg io_space_select_o;
  output reg io_space_select_oe;
  output reg transfer_direction_o;
  output reg transfer_direction_oe;
  output reg read_pin_o;
  output reg read_pin_oe;
  output reg write_strobe_o;
  output reg write_strobe_oe;
  output reg cycle_strobe_o;
  output reg cycle_strobe_oe;
  output reg [15:0] data_out;
  output reg data_oe;

  // ****************************************************************
  // Sequencer states
  // ****************************************************************
  localparam ST_IDLE = 2'b00;
  localparam ST_SETUP = 2'b01;
  localparam ST_STROBE = 2'b10;
  localparam ST_END = 2'b11;

  reg [1:0] state_q;
  reg [1:0] state_d;
  reg [1:0] space_q;
  reg write_q;
  reg [15:0] wdata_q;
  wire ready_s;
  wire float_n_s;
  wire rd_fn;

  // ****************************************************************
  // Pin input synchronisers
  // ****************************************************************
  emb_sync #(.RESET_VALUE(1'b1)) u_sync_ready (
    .clock(clock),
    .reset(reset),
    .async_in(ready),
    .sync_out(ready_s)
  );

  emb_sync #(.RESET_VALUE(1'b1)) u_sync_float (
    .clock(clock),
    .reset(reset),
    .async_in(bus_float_n),
    .sync_out(float_n_s)
  );

  assign rd_fn = mode_value[`EMB_MODE_RDFN_BIT];

  // Select one space line from the access space
  function sel_low;
    input [1:0] space;
    input [1:0] want;
    begin
      sel_low = (space == want);
    end
  endfunction

  // ****************************************************************
  // Next-state logic
  // ****************************************************************
  always @* begin
    state_d = state_q;
    case (state_q)
      ST_IDLE: begin
        if (req_valid && req_ready) begin
          state_d = ST_SETUP;
        end
      end
      ST_SETUP: begin
        state_d = ST_STROBE;
      end
      ST_STROBE: begin
        if (ready_s) begin
          state_d = ST_END;
        end
      end
      ST_END: begin
        state_d = ST_IDLE;
      end
      default: begin
        state_d = ST_IDLE;
      end
    endcase
  end

  // Sequencer, request capture, mode register and core handshake
  always @(posedge clock or posedge reset) begin
    if (reset) begin
      state_q <= ST_IDLE;
      space_q <= `EMB_SPACE_PROG;
      write_q <= 1'b0;
      wdata_q <= 16'h0000;
      mode_value <= `EMB_MODE_RESET;
      req_ready <= 1'b0;
      done_pulse <= 1'b0;
      rdata <= 16'h0000;
    end else begin
      state_q <= state_d;
      done_pulse <= 1'b0;
      if (mode_wr) begin
        mode_value <= mode_wdata;
      end
      if (state_q == ST_IDLE && req_valid && req_ready) begin
        space_q <= req_space;
        write_q <= req_write;
        wdata_q <= req_wdata;
        req_ready <= 1'b0;
      end else if (state_d == ST_IDLE) begin
        req_ready <= 1'b1;
      end
      if (state_q == ST_STROBE && ready_s) begin
        done_pulse <= 1'b1;
        if (!write_q) begin
          rdata <= data_in; // Read data taken at end of strobe
        end
      end
    end
  end

  // ****************************************************************
  // Pin drivers, all registered
  // ****************************************************************
  always @(posedge clock or posedge reset) begin
    if (reset) begin
      program_space_select_o <= 1'b1;
      data_space_select_o <= 1'b1;
      io_space_select_o <= 1'b1;
      transfer_direction_o <= 1'b1;
      read_pin_o <= 1'b1;
      write_strobe_o <= 1'b1;
      cycle_strobe_o <= 1'b1;
      data_out <= 16'h0000;
      data_oe <= 1'b0;
      program_space_select_oe <= 1'b0;
      data_space_select_oe <= 1'b0;
      io_space_select_oe <= 1'b0;
      transfer_direction_oe <= 1'b0;
      read_pin_oe <= 1'b0;
      write_strobe_oe <= 1'b0;
      cycle_strobe_oe <= 1'b0;
    end else begin
      // Active while the access occupies the bus
      if (state_d == ST_SETUP || state_d == ST_STROBE || state_d == ST_END) begin
        program_space_select_o <= ~sel_low(state_d == ST_SETUP ? req_space : space_q,
          `EMB_SPACE_PROG);
        data_space_select_o <= ~sel_low(state_d == ST_SETUP ? req_space : space_q,
          `EMB_SPACE_DATA);
        io_space_select_o <= ~sel_low(state_d == ST_SETUP ? req_space : space_q,
          `EMB_SPACE_IO);
        transfer_direction_o <= ~(state_d == ST_SETUP ? req_write : write_q);
      end else begin
        program_space_select_o <= 1'b1;
        data_space_select_o <= 1'b1;
        io_space_select_o <= 1'b1;
        transfer_direction_o <= 1'b1;
      end
      // Strobes low only in the strobe phase
      if (state_d == ST_STROBE) begin
        cycle_strobe_o <= 1'b0;
        write_strobe_o <= ~write_q;
        if (rd_fn) begin
          read_pin_o <= write_q;
        end else begin
          read_pin_o <= write_q;
        end
      end else begin
        cycle_strobe_o <= 1'b1;
        write_strobe_o <= 1'b1;
        if (rd_fn && (state_d == ST_SETUP || state_d == ST_END)) begin
          read_pin_o <= state_d == ST_SETUP ? req_write : write_q;
        end else begin
          read_pin_o <= 1'b1;
        end
      end
      // Data driven from write strobe fall through the end phase
      if (state_d == ST_STROBE && write_q) begin
        data_out <= wdata_q;
        data_oe <= float_n_s;
      end else if (state_d != ST_END) begin
        data_oe <= 1'b0;
      end else begin
        data_oe <= data_oe & float_n_s; // Hold past strobe rise for capture
      end
      // Float all controls while bus_float_n is low
      program_space_select_oe <= float_n_s;
      data_space_select_oe <= float_n_s;
      io_space_select_oe <= float_n_s;
      transfer_direction_oe <= float_n_s;
      read_pin_oe <= float_n_s;
      write_strobe_oe <= float_n_s;
      cycle_strobe_oe <= float_n_s;
    end
  end
endmodule

/* tb/emb_ctrl_assertions.sv */
// Assertions on the memory control pins of emb_ctrl.
// Assumes it is bound to emb_ctrl and sees only its ports.
`timescale 1ns/1ps
module emb_chk (
  input logic clock,
  input logic reset,
  input logic req_valid,
  input logic req_ready,
  input logic [1:0] req_space,
  input logic req_write,
  input logic ready,
  input logic bus_float_n,
  input logic done_pulse,
  input logic program_space_select_o,
  input logic data_space_select_o,
  input logic io_space_select_o,
  input logic transfer_direction_o,
  input logic read_pin_o,
  input logic write_strobe_o,
  input logic cycle_strobe_o,
  input logic cycle_strobe_oe
);
  default clocking @(posedge clock); endclocking
  default disable iff (reset);
  // Request taken at this edge
  wire tk = req_valid && req_ready;
  wire [2:0] sel = {program_space_select_o, data_space_select_o, io_space_select_o};
  a_space_sel: assert property (tk |-> ##2 sel == ~(3'h4 >> $past(req_space, 2)))
    else $error("wrong space select");
  a_one_sel: assert property ($onehot0(~sel))
    else $error("several space selects low");
  a_dir_read: assert property (tk && !req_write |-> transfer_direction_o [*4])
    else $error("direction low on a read");
  a_write_stb: assert property (tk && req_write |-> ##[1:3] !write_strobe_o)
    else $error("write strobe missing");
  a_read_pin: assert property (tk && !req_write |-> ##[1:3] !read_pin_o)
    else $error("read pin missing");
  a_ready_wait: assert property (!ready [*4] |-> !done_pulse)
    else $error("access ended while not ready");
  a_float_oe: assert property (!bus_float_n [*4] |-> !cycle_strobe_oe)
    else $error("strobe driven while floated");
  a_idle_strobe: assert property (req_ready |-> cycle_strobe_o && transfer_direction_o)
    else $error("strobe or direction low while idle");
  // Main scenarios reached
  c_write: cover property (tk && req_write);
  c_wait: cover property (!ready [*4] ##1 ready);
  c_float: cover property (!bus_float_n [*4]);
endmodule
bind emb_ctrl emb_chk chk (.clock, .reset, .req_valid, .req_ready, .req_space, .req_write,
  .ready, .bus_float_n, .done_pulse, .program_space_select_o, .data_space_select_o,
  .io_space_select_o, .transfer_direction_o, .read_pin_o, .write_strobe_o, .cycle_strobe_o,
  .cycle_strobe_oe);

/* tb/emb_mem.sv */
// Far-side memory model: one word of storage and ready stretching.
// Assumes active-low selects and strobes from emb_ctrl.
`timescale 1ns/1ps
module emb_mem (
  input logic clock,
  input logic sel_n,
  input logic rd_n,
  input logic we_n,
  input logic [15:0] wdata,
  input logic [3:0] waits,
  output logic ready,
  output logic [15:0] rdata,
  output logic [15:0] word
);
  logic [3:0] cnt_q = 4'h0;
  logic [15:0] last_q = 16'h0000;
  // Count selected cycles; remember the bus so a released bus shows its inverse
  always @(posedge clock) begin
    cnt_q <= sel_n ? 4'h0 : cnt_q + 4'h1;
    last_q <= rdata;
  end
  // Slow device holds ready low until waits have passed; waits of zero ties it high
  assign ready = cnt_q >= waits;
  assign rdata = !rd_n ? word : ~last_q;
  // Capture write data on the rising write strobe
  always @(posedge we_n) word <= wdata;
endmodule

/* tb/tb_top.sv */
// Bench for emb_ctrl: accesses in every space against a memory model.
// Assumes a 40 MHz clock and an access that ends two edges after take when ready is high.
`timescale 1ns/1ps
module tb_top;
  logic clock = 1'b0;
  logic reset = 1'b1;
  logic req_valid = 1'b0;
  logic req_write = 1'b0;
  logic mode_wr = 1'b0;
  logic bus_float_n = 1'b1;
  logic [1:0] req_space = 2'h0;
  logic [15:0] req_wdata = 16'h0000;
  logic [15:0] mode_wdata = 16'h0000;
  logic [3:0] waits = 4'h0;
  wire req_ready, done_pulse, ready, data_oe;
  wire [15:0] rdata, mode_value, data_in, data_out, word;
  wire [6:0] pin, oe;
  int err_count = 0;
  int cmp_count = 0;
  // Design and memory model; pins gathered as selects, direction, read, write, strobe
  emb_ctrl uut (.clock, .reset, .req_valid, .req_space, .req_write, .req_wdata, .req_ready,
    .done_pulse, .rdata, .mode_wr, .mode_wdata, .mode_value, .ready, .bus_float_n, .data_in,
    .program_space_select_o(pin[6]), .program_space_select_oe(oe[6]),
    .data_space_select_o(pin[5]), .data_space_select_oe(oe[5]),
    .io_space_select_o(pin[4]), .io_space_select_oe(oe[4]),
    .transfer_direction_o(pin[3]), .transfer_direction_oe(oe[3]),
    .read_pin_o(pin[2]), .read_pin_oe(oe[2]), .write_strobe_o(pin[1]), .write_strobe_oe(oe[1]),
    .cycle_strobe_o(pin[0]), .cycle_strobe_oe(oe[0]), .data_out, .data_oe);
  emb_mem mem (.clock, .sel_n(&pin[6:4]), .rd_n(pin[2]), .we_n(pin[1]), .wdata(data_out),
    .waits, .ready, .rdata(data_in), .word);
  // Clock at 25 ns
  initial forever #12.5 clock = ~clock;
  // Compare one value
  task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
    cmp_count++;
    if (got !== exp) begin
      err_count++;
      $display("FAIL %s expected %h seen %h", nm, exp, got);
    end
  endtask
  // Report counts and end the run
  task automatic summarize();
    $display("Comparisons %0d mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  // One access; returns cycles from take to done and the read word
  task automatic acc(input logic [1:0] sp, input logic wr, input logic [15:0] wd,
      output int lat, output logic [15:0] rd);
    int n;
    n = 0;
    while (req_ready !== 1'b1 && n < 20) begin
      @(posedge clock);
      #2 n++;
    end
    req_space = sp;
    req_write = wr;
    req_wdata = wd;
    req_valid = 1'b1;
    @(posedge clock);
    #2 req_valid = 1'b0;
    lat = 0;
    while (done_pulse !== 1'b1 && lat < 20) begin
      @(posedge clock);
      #2 lat++;
    end
    rd = rdata;
    if (n == 20 || lat == 20) begin
      err_count++;
      summarize();
    end
  endtask
  // Back-to-back write and read in each space
  task automatic t_spaces();
    int lat;
    logic [15:0] rd;
    for (int s = 0; s < 3; s++) begin
      acc(2'(s), 1'b1, 16'ha5c0 + 16'(s), lat, rd);
      chk("latency", 16'h0002, 16'(lat));
      chk("captured word", 16'ha5c0 + 16'(s), word);
      chk("write data enable", 16'h0001, 16'(data_oe));
      acc(2'(s), 1'b0, 16'h0000, lat, rd);
      chk("read latency", 16'h0002, 16'(lat));
      chk("read word", 16'ha5c0 + 16'(s), rd);
      chk("read data enable", 16'h0000, 16'(data_oe));
      chk("read pin at end", 16'h0001, 16'(pin[2]));
    end
  endtask
  // Slow device stretches a read
  task automatic t_wait();
    int lat;
    logic [15:0] rd;
    waits = 4'h5;
    acc(2'h1, 1'b0, 16'h0000, lat, rd);
    chk("stretched", 16'h0001, 16'(lat >= 8 && lat <= 11));
    waits = 4'h0;
  endtask
  // Read pin carries inverted direction
  task automatic t_mode();
    int lat;
    logic [15:0] rd;
    chk("mode reset", 16'h0000, mode_value);
    mode_wdata = 16'h8000;
    mode_wr = 1'b1;
    @(posedge clock);
    #2 mode_wr = 1'b0;
    chk("mode set", 16'h8000, mode_value);
    acc(2'h2, 1'b1, 16'h1234, lat, rd);
    acc(2'h2, 1'b0, 16'h0000, lat, rd);
    chk("inverted read", 16'h1234, rd);
    // Inverted direction keeps the read pin low through the end phase
    chk("read pin at end", 16'h0000, 16'(pin[2]));
  endtask
  // Float all outputs, then drive again at rest levels
  task automatic t_float();
    bus_float_n = 1'b0;
    repeat (5) @(posedge clock);
    #2 chk("floated", 16'h0000, {9'h000, oe});
    bus_float_n = 1'b1;
    repeat (5) @(posedge clock);
    #2 chk("rest", 16'h3fff, {2'h0, pin, oe});
  endtask
  // Main sequence
  initial begin
    repeat (16) @(posedge clock);
    #2 reset = 1'b0;
    repeat (4) @(posedge clock);
    #2 t_spaces();
    t_wait();
    t_mode();
    t_float();
    summarize();
  end
endmodule
